// [rtl/sys_tick_defines.vh]
// Register offsets, reset values and field positions of the system tick chain.
// Included by the tick chain module; holds definitions only.
`ifndef SYS_TICK_DEFINES_VH
`define SYS_TICK_DEFINES_VH

`define ADDR_SECONDS_INTERVAL   8'hF9
`define ADDR_MILLISECOND_INTVL  8'hFA
`define ADDR_MICRO_DIVIDER      8'hFB
`define ADDR_BASE_DIV_LOW       8'hFC
`define ADDR_BASE_DIV_HIGH      8'hFD
`define ADDR_DECADE_DIVIDER     8'hFE

`define RST_SECONDS_INTERVAL    7'h7F
`define RST_MILLISECOND_INTVL   7'h7F
`define RST_MICRO_DIVIDER       6'h03
`define RST_BASE_DIV_LOW        8'h9F
`define RST_BASE_DIV_HIGH       8'h0F
`define RST_DECADE_DIVIDER      7'h63

`define LOAD_NOW_BIT            7
`define BYTES_PER_HIGH          16'h0100

`endif

// [rtl/system_tick_timers.v]
// System tick chain: base, micro and decade dividers plus two interval counters.
// Assumes a single-cycle register port from the processor core on the same clock.
//
// Overview of operation
// - Base tick divides clock by high*256+low+1
// - Decade tick divides base tick by value+1
// - Seconds counter runs from the decade tick
// - Seconds interrupt period is product of three divisors
// - Reading seconds register clears seconds interrupt
// - Seconds interrupt visible for enable and poll
// - Millisecond counter runs from base tick
// - Reading millisecond register clears millisecond interrupt
// - Load-now bit always reads back zero
// - Load-now zero: new count waits for expiry
// - Load-now one: counter loads at write
// - Micro tick divides clock by value+1
// - Micro tick goes to flash write timing
// - Base tick goes to flash erase timing
// - Power-down bit stops the whole chain
`timescale 1ns/1ps
`include "sys_tick_defines.vh"

module system_tick_timers (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    input  wire       tick_power_down,
    output reg        micro_tick,
    output reg        base_tick,
    output reg        decade_tick,
    output reg        seconds_irq,
    output reg        millisecond_irq
);

    wire [5:0]  micro_div_q;
    wire [7:0]  base_low_q;
    wire [7:0]  base_high_q;
    wire [6:0]  sec_reload_q;
    wire [6:0]  ms_reload_q;
    wire [6:0]  decade_reload_q;
    reg         pd_meta_q;
    reg         pd_q;
    reg  [7:0]  rdata_d;

    wire [15:0] base_divisor;
    wire        run;
    wire        base_wrap;
    wire        micro_wrap;
    wire        decade_wrap;
    wire        sec_wrap;
    wire        ms_wrap;
    wire        load_now;
    wire        wr_micro;
    wire        wr_low;
    wire        wr_high;
    wire        wr_sec;
    wire        wr_ms;
    wire        wr_dec;
    wire        rd_sec;
    wire        rd_ms;

    // Processor power-down strap may come from another block; synchronise it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_meta_q <= 1'b0;
            pd_q      <= 1'b0;
        end else begin
            pd_meta_q <= tick_power_down;
            pd_q      <= pd_meta_q;
        end
    end

    assign run          = ~pd_q;
    assign base_divisor = {base_high_q, base_low_q};
    assign load_now     = reg_wdata[`LOAD_NOW_BIT];
    assign wr_micro     = reg_wr && (reg_addr == `ADDR_MICRO_DIVIDER);
    assign wr_low       = reg_wr && (reg_addr == `ADDR_BASE_DIV_LOW);
    assign wr_high      = reg_wr && (reg_addr == `ADDR_BASE_DIV_HIGH);
    assign wr_sec       = reg_wr && (reg_addr == `ADDR_SECONDS_INTERVAL);
    assign wr_ms        = reg_wr && (reg_addr == `ADDR_MILLISECOND_INTVL);
    assign wr_dec       = reg_wr && (reg_addr == `ADDR_DECADE_DIVIDER);
    assign rd_sec       = reg_rd && (reg_addr == `ADDR_SECONDS_INTERVAL);
    assign rd_ms        = reg_rd && (reg_addr == `ADDR_MILLISECOND_INTVL);

    // Divider settings; a new divisor applies at the next compare, no restart
    config_register #(
        .WIDTH       (6),
        .RESET_VALUE (`RST_MICRO_DIVIDER)
    ) micro_divider_i (
        .clk         (clk),
        .rst_n       (rst_n),
        .write_en    (wr_micro),
        .write_value (reg_wdata[5:0]),
        .value_q     (micro_div_q)
    );

    config_register #(
        .WIDTH       (8),
        .RESET_VALUE (`RST_BASE_DIV_LOW)
    ) base_low_i (
        .clk         (clk),
        .rst_n       (rst_n),
        .write_en    (wr_low),
        .write_value (reg_wdata),
        .value_q     (base_low_q)
    );

    config_register #(
        .WIDTH       (8),
        .RESET_VALUE (`RST_BASE_DIV_HIGH)
    ) base_high_i (
        .clk         (clk),
        .rst_n       (rst_n),
        .write_en    (wr_high),
        .write_value (reg_wdata),
        .value_q     (base_high_q)
    );

    // A divisor lowered below the running count takes effect only after the
    // prescaler wraps at its full width
    wrap_counter #(
        .WIDTH (16)
    ) base_prescaler_i (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (run),
        .limit (base_divisor),
        .wrap  (base_wrap)
    );

    wrap_counter #(
        .WIDTH (6)
    ) micro_prescaler_i (
        .clk   (clk),
        .rst_n (rst_n),
        .run   (run),
        .limit (micro_div_q),
        .wrap  (micro_wrap)
    );

    // Interval chain: decade divider, then the seconds counter; millisecond counter steps on the base tick
    reload_down_counter #(
        .RESET_VALUE (`RST_DECADE_DIVIDER)
    ) decade_count_i (
        .clk         (clk),
        .rst_n       (rst_n),
        .write_en    (wr_dec),
        .write_value (reg_wdata[6:0]),
        .load_now    (load_now),
        .step        (base_wrap),
        .reload_q    (decade_reload_q),
        .expired     (decade_wrap)
    );

    reload_down_counter #(
        .RESET_VALUE (`RST_SECONDS_INTERVAL)
    ) seconds_count_i (
        .clk         (clk),
        .rst_n       (rst_n),
        .write_en    (wr_sec),
        .write_value (reg_wdata[6:0]),
        .load_now    (load_now),
        .step        (decade_wrap),
        .reload_q    (sec_reload_q),
        .expired     (sec_wrap)
    );

    reload_down_counter #(
        .RESET_VALUE (`RST_MILLISECOND_INTVL)
    ) millisecond_count_i (
        .clk         (clk),
        .rst_n       (rst_n),
        .write_en    (wr_ms),
        .write_value (reg_wdata[6:0]),
        .load_now    (load_now),
        .step        (base_wrap),
        .reload_q    (ms_reload_q),
        .expired     (ms_wrap)
    );

    // Tick outputs are one-cycle registered pulses
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            micro_tick  <= 1'b0;
            base_tick   <= 1'b0;
            decade_tick <= 1'b0;
        end else begin
            micro_tick  <= micro_wrap;
            base_tick   <= base_wrap;
            decade_tick <= decade_wrap;
        end
    end

    // Sticky flags; an expiry in the read cycle wins so no period is lost
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seconds_irq <= 1'b0;
        end else if (sec_wrap) begin
            seconds_irq <= 1'b1;
        end else if (rd_sec) begin
            seconds_irq <= 1'b0;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            millisecond_irq <= 1'b0;
        end else if (ms_wrap) begin
            millisecond_irq <= 1'b1;
        end else if (rd_ms) begin
            millisecond_irq <= 1'b0;
        end
    end

    // Read data shows reload values, not live counts; load-now bit reads zero
    always @* begin
        case (reg_addr)
            `ADDR_SECONDS_INTERVAL: begin
                rdata_d = {1'b0, sec_reload_q};
            end
            `ADDR_MILLISECOND_INTVL: begin
                rdata_d = {1'b0, ms_reload_q};
            end
            `ADDR_MICRO_DIVIDER: begin
                rdata_d = {2'b00, micro_div_q};
            end
            `ADDR_BASE_DIV_LOW: begin
                rdata_d = base_low_q;
            end
            `ADDR_BASE_DIV_HIGH: begin
                rdata_d = base_high_q;
            end
            `ADDR_DECADE_DIVIDER: begin
                rdata_d = {1'b0, decade_reload_q};
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

endmodule

// Up counter that wraps at its limit; the limit is compared every cycle,
// so a new divisor is picked up without restarting the count.
module wrap_counter #(
    parameter WIDTH = 16
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             run,
    input  wire [WIDTH-1:0] limit,
    output wire             wrap
);

    reg [WIDTH-1:0] count_q;

    assign wrap = run && (count_q == limit);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= {WIDTH{1'b0}};
        end else if (wrap) begin
            count_q <= {WIDTH{1'b0}};
        end else if (run) begin
            count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule

// Reloading down counter with its reload register. A write with the load-now
// bit restarts the count at once; otherwise the new value waits for expiry,
// so the running period is never cut short.
module reload_down_counter #(
    parameter [6:0] RESET_VALUE = 7'h7F
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       write_en,
    input  wire [6:0] write_value,
    input  wire       load_now,
    input  wire       step,
    output reg  [6:0] reload_q,
    output wire       expired
);

    reg [6:0] count_q;

    assign expired = step && (count_q == 7'h00);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_q <= RESET_VALUE;
        end else if (write_en) begin
            reload_q <= write_value;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= RESET_VALUE;
        end else if (write_en && load_now) begin
            count_q <= write_value;
        end else if (expired) begin
            count_q <= reload_q;
        end else if (step) begin
            count_q <= count_q - 7'h01;
        end
    end

endmodule

// Plain read-write setting register with a reset value.
// Written whole in the cycle that its write enable is high.
module config_register #(
    parameter             WIDTH       = 8,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             write_en,
    input  wire [WIDTH-1:0] write_value,
    output reg  [WIDTH-1:0] value_q
);

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= RESET_VALUE;
        end else if (write_en) begin
            value_q <= write_value;
        end
    end

endmodule

// [verification/system_tick_timers_props.sv]
// Port assertions for the system tick chain.
// Bound into every system_tick_timers instance; reads its ports only.
`timescale 1ns/1ps
module system_tick_timers_props (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       tick_power_down,
    input wire logic       micro_tick,
    input wire logic       base_tick,
    input wire logic       decade_tick,
    input wire logic       seconds_irq,
    input wire logic       millisecond_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Expiry in the read cycle wins, so a fresh tick excuses a flag still set
    wire rd_ms  = reg_rd && reg_addr == 8'hFA;
    wire rd_sec = reg_rd && reg_addr == 8'hF9;
    a_pd_freeze: assert property (
        tick_power_down [*5] |-> !(micro_tick || base_tick || decade_tick)) else $error("pd tick");
    a_ms_read_clr: assert property (
        rd_ms |=> !millisecond_irq || base_tick) else $error("ms flag kept");
    a_sec_read_clr: assert property (
        rd_sec |=> !seconds_irq || decade_tick) else $error("sec flag kept");
    a_ms_on_base: assert property (
        $rose(millisecond_irq) |-> base_tick) else $error("ms flag off tick");
    a_sec_on_decade: assert property (
        $rose(seconds_irq) |-> decade_tick) else $error("sec flag off tick");
    a_decade_on_base: assert property (
        decade_tick |-> base_tick) else $error("decade off base");
    a_sec_held: assert property (
        seconds_irq && !rd_sec |=> seconds_irq) else $error("sec flag lost");
    a_load_bit_zero: assert property (
        reg_addr inside {8'hF9, 8'hFA, 8'hFE} |=> !reg_rdata[7]) else $error("bit7 set");
endmodule
bind system_tick_timers system_tick_timers_props system_tick_timers_props_i (
    .clk             (clk),
    .rst_n           (rst_n),
    .reg_addr        (reg_addr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .tick_power_down (tick_power_down),
    .micro_tick      (micro_tick),
    .base_tick       (base_tick),
    .decade_tick     (decade_tick),
    .seconds_irq     (seconds_irq),
    .millisecond_irq (millisecond_irq)
);

// [verification/system_tick_timers_tb_top.sv]
// Directed bench for the tick chain: register access tasks and period checks.
// Drives every port itself on one 125 MHz clock; dividers are kept small.
`timescale 1ns/1ps
module system_tick_timers_tb_top;
    logic       clk = 1'b0;
    logic       rst_n, reg_wr, reg_rd, tick_power_down;
    logic [7:0] reg_addr, reg_wdata;
    wire  [7:0] reg_rdata;
    wire        micro_tick, base_tick, decade_tick, seconds_irq, millisecond_irq;
    wire  [4:0] t = {seconds_irq, millisecond_irq, decade_tick, base_tick, micro_tick};
    logic [7:0] rst_tab [8] = '{8'h00, 8'h7F, 8'h7F, 8'h03, 8'h9F, 8'h0F, 8'h63, 8'h00};
    int         bad_count = 0;
    int         checked = 0;
    int         n;
    system_tick_timers system_tick_timers_i (
        .clk             (clk),
        .rst_n           (rst_n),
        .reg_addr        (reg_addr),
        .reg_wr          (reg_wr),
        .reg_rd          (reg_rd),
        .reg_wdata       (reg_wdata),
        .reg_rdata       (reg_rdata),
        .tick_power_down (tick_power_down),
        .micro_tick      (micro_tick),
        .base_tick       (base_tick),
        .decade_tick     (decade_tick),
        .seconds_irq     (seconds_irq),
        .millisecond_irq (millisecond_irq)
    );
    initial forever #4 clk = ~clk;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %0h, expected %0h", $time, got, exp);
        end
    endtask
    // Strobes drop for a cycle between accesses so no edge sees one twice
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
        @(posedge clk) #1;
        {reg_wr, reg_rd} = 2'b00;
        @(posedge clk) #1;
        if (!w)
            check(reg_rdata, d);
    endtask
    task automatic wait_for(input int s);
        n = 0;
        while (t[s] !== 1'b1 && n < 9000) begin
            @(posedge clk) #1;
            n++;
        end
    endtask
    // Period between two events; a flag is cleared by a read in between
    task automatic per(input int s, input logic [7:0] a, input logic [7:0] e, input int p);
        wait_for(s);
        if (a !== 8'h00)
            acc(1'b0, a, e);
        @(posedge clk) #1;
        wait_for(s);
        check(16'(n + ((a !== 8'h00) ? 3 : 1)), 16'(p));
    endtask
    task automatic close_out;
        $display("Checks %0d, errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        {rst_n, reg_wr, reg_rd, tick_power_down, reg_addr, reg_wdata} = '0;
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        foreach (rst_tab[i])
            acc(1'b0, 8'hF8 + 8'(i), rst_tab[i]);
        acc(1'b1, 8'hFB, 8'hC5);
        per(0, 8'h00, 8'h00, 6);
        acc(1'b1, 8'hFC, 8'h03);
        acc(1'b1, 8'hFD, 8'h01);
        per(1, 8'h00, 8'h00, 260);
        acc(1'b1, 8'hFD, 8'h00);
        acc(1'b1, 8'hFA, 8'h81);
        per(3, 8'hFA, 8'h01, 8);
        acc(1'b1, 8'hFA, 8'h02);
        acc(1'b0, 8'hFA, 8'h02);
        per(3, 8'hFA, 8'h02, 12);
        acc(1'b1, 8'hFA, 8'hFF);
        acc(1'b0, 8'hFA, 8'h7F);
        check(16'(millisecond_irq), 16'h0000);
        acc(1'b1, 8'hFA, 8'h81);
        wait_for(3);
        check(16'(n < 9), 16'h0001);
        acc(1'b1, 8'hFE, 8'h82);
        per(2, 8'h00, 8'h00, 12);
        acc(1'b1, 8'hF9, 8'h81);
        per(4, 8'hF9, 8'h01, 24);
        tick_power_down = 1'b1;
        repeat (5) @(posedge clk) #1;
        wait_for(1);
        check(16'(n), 16'd9000);
        tick_power_down = 1'b0;
        wait_for(1);
        check(16'(n < 9), 16'h0001);
        close_out;
    end
    initial begin
        #400000 bad_count++;
        close_out;
    end
endmodule
